// >>> rtl/adc_pkg.sv
// Shared constants and types of the converter digital output port.
package adc_pkg;

    // Sample format and pipeline shape.
    localparam int unsigned SAMPLE_WIDTH = 10;
    localparam int unsigned PIPE_LATENCY = 2;
    localparam int unsigned FIFO_DEPTH   = 8;

    // Conversion rate limit against the system clock.
    localparam int unsigned SYS_CLK_PERIOD_NS      = 10;
    localparam int unsigned CONV_RATE_MAX_MSPS     = 25;
    localparam int unsigned CONV_PERIOD_MIN_NS     = 1000 / CONV_RATE_MAX_MSPS;
    localparam int unsigned CONV_PERIOD_MIN_CYCLES =
        (CONV_PERIOD_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned GAP_WIDTH              = 4;

    // Reset values.
    localparam logic [SAMPLE_WIDTH-1:0] DATA_RESET      = 10'h000;
    localparam logic                    DRIVE_RESET     = 1'h0;
    localparam logic                    STANDBY_RESET   = 1'h1;
    localparam logic                    VIOLATION_RESET = 1'h0;
    localparam logic                    CONV_CLK_RESET  = 1'h0;

    // Converter operating state.
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_FILL    = 3'b010,
        ST_RUN     = 3'b100
    } state_type;

endpackage

// >>> rtl/adc_word_if.sv
// Valid/ready word channel between the port core and its sample FIFO.
`timescale 1ns/1ps
interface adc_word_if #(
    parameter int unsigned WIDTH = 10
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/adc_conv_clk_edge.sv
// Falling edge detector for the conversion clock pin.
`timescale 1ns/1ps
module adc_conv_clk_edge
    import adc_pkg::*;
(
    // System side
    input  wire logic i_sys_clk,
    input  wire logic i_rst_n,
    // Conversion clock pin
    input  wire logic i_conv_clk,
    // One-cycle pulse per falling edge
    output logic      o_fall
);
    typedef struct packed {
        logic prev;
        logic fall;
    } edge_state_type;

    edge_state_type q;
    edge_state_type d;

    // Previous level resets low so a clock held low at release is no edge.
    always_comb begin
        d.prev = i_conv_clk;
        d.fall = q.prev & ~i_conv_clk;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{prev: CONV_CLK_RESET, fall: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_fall = q.fall;
endmodule

// >>> rtl/adc_sample_fifo.sv
// Sample FIFO holding conversions in flight through the pipeline.
`timescale 1ns/1ps
module adc_sample_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 8
) (
    // System side
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_flush,
    // Word channels
    adc_word_if.snk                         wr,
    adc_word_if.src                         rd,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0]      o_level
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned LW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
        $error("FIFO needs a depth of at least two words.");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd_ptr;
        logic [AW-1:0]               wr_ptr;
        logic [LW-1:0]               level;
    } fifo_state_type;

    fifo_state_type q;
    fifo_state_type d;
    logic           push;
    logic           pop;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_comb begin
        wr.ready = (q.level != LW'(DEPTH));
        rd.valid = (q.level != '0);
        rd.data  = q.mem[q.rd_ptr];
        push     = wr.valid & wr.ready;
        pop      = rd.valid & rd.ready;
        d        = q;
        if (push) begin
            d.mem[q.wr_ptr] = wr.data;
            d.wr_ptr        = next_ptr(q.wr_ptr);
        end
        if (pop) begin
            d.rd_ptr = next_ptr(q.rd_ptr);
        end
        if (push && !pop) begin
            d.level = LW'(q.level + 1'b1);
        end else if (pop && !push) begin
            d.level = LW'(q.level - 1'b1);
        end
        // Flush drops everything in flight; stored words need no clearing.
        if (i_flush) begin
            d.rd_ptr = '0;
            d.wr_ptr = '0;
            d.level  = '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_level = q.level;
endmodule

// >>> rtl/adc_parallel_output_port.sv
// Digital side of a sampling converter: sampling, pipeline and tri-state output port.
//
// Contract
// - Capture the input level on every conversion clock falling edge, one conversion each.
// - A sample's result reaches the output bus two conversion clock falling edges after its own edge.
// - Results are ten-bit straight binary, lowest input zeros, highest input ones.
// - Standby request high stops conversion and floats outputs regardless of enable.
// - Outputs are driven only while output enable and standby request are both low.
// - Ten parallel output lines, bit zero least significant, bit nine most significant.
// - Output word changes just after each falling edge; capture samples after it.
`timescale 1ns/1ps
module adc_parallel_output_port
    import adc_pkg::*;
#(
    parameter int unsigned WIDTH   = SAMPLE_WIDTH,
    parameter int unsigned LATENCY = PIPE_LATENCY,
    parameter int unsigned DEPTH   = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_arst_n,
    // Conversion clock and quantised input level
    input  wire logic             i_conv_clk,
    input  wire logic [WIDTH-1:0] i_analog_level,
    // Control pins
    input  wire logic             i_standby_request,
    input  wire logic             i_output_enable_n,
    // Parallel data pins
    output logic [WIDTH-1:0]      o_sample_word_lines,
    output logic [WIDTH-1:0]      o_sample_word_lines_oe,
    // Status
    output logic                  o_standby_active,
    output logic                  o_rate_violation
);
    localparam int unsigned LW = $clog2(DEPTH + 1);

    if (LATENCY < 1 || LATENCY >= DEPTH || WIDTH < 1) begin : g_bad_shape
        $error("Pipeline latency must be at least one and below the FIFO depth.");
    end
    if (CONV_PERIOD_MIN_CYCLES >= (1 << GAP_WIDTH)) begin : g_bad_gap
        $error("Edge gap counter too narrow for the minimum conversion period.");
    end

    // Reset release.
    typedef struct packed {
        logic [1:0] sync;
    } rst_state_type;

    rst_state_type rst_q;
    rst_state_type rst_d;
    logic          rst_n;

    always_comb begin
        rst_d.sync = {rst_q.sync[0], 1'b1};
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_q <= '0;
        end else begin
            rst_q <= rst_d;
        end
    end

    assign rst_n = rst_q.sync[1];

    // Core state.
    typedef struct packed {
        state_type              st;
        logic [WIDTH-1:0]       data;
        logic [WIDTH-1:0]       oe;
        logic                   standby;
        logic                   rate_viol;
        logic [GAP_WIDTH-1:0]   gap;
    } core_state_type;

    core_state_type q;
    core_state_type d;

    logic           conv_fall;
    logic           flush;
    logic [LW-1:0]  level;

    adc_word_if #(.WIDTH(WIDTH)) wr_ch ();
    adc_word_if #(.WIDTH(WIDTH)) rd_ch ();

    adc_conv_clk_edge u_edge (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (rst_n),
        .i_conv_clk (i_conv_clk),
        .o_fall     (conv_fall)
    );

    // The FIFO only ever holds LATENCY words, so it never back-pressures in
    // normal use; if it ever did, the sample is skipped rather than overwritten.
    adc_sample_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n),
        .i_flush   (flush),
        .wr        (wr_ch.snk),
        .rd        (rd_ch.src),
        .o_level   (level)
    );

    always_comb begin
        d           = q;
        flush       = 1'b0;
        wr_ch.valid = 1'b0;
        // Straight binary: the quantised level passes unchanged, bit 0 as LSB.
        wr_ch.data  = i_analog_level;
        rd_ch.ready = 1'b0;

        // Edge spacing measured in system cycles, saturating.
        if (conv_fall) begin
            d.gap = '0;
        end else if (q.gap != '1) begin
            d.gap = GAP_WIDTH'(q.gap + 1'b1);
        end

        unique case (q.st)
            ST_STANDBY: begin
                // Pipeline contents are stale after standby and are dropped.
                flush       = 1'b1;
                d.rate_viol = 1'b0;
                if (!i_standby_request) begin
                    d.st = ST_FILL;
                end
            end
            ST_FILL: begin
                if (i_standby_request) begin
                    d.st = ST_STANDBY;
                end else if (conv_fall) begin
                    wr_ch.valid = 1'b1;
                    if (wr_ch.ready && level == LW'(LATENCY - 1)) begin
                        d.st = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (i_standby_request) begin
                    d.st = ST_STANDBY;
                end else if (conv_fall) begin
                    wr_ch.valid = 1'b1;
                    rd_ch.ready = 1'b1;
                    // The word leaving the FIFO was taken LATENCY edges ago.
                    if (rd_ch.valid) begin
                        d.data = rd_ch.data;
                    end
                end
            end
            default: begin
                d.st = ST_STANDBY;
            end
        endcase

        // Too close a pair of edges means the clock runs above the rated rate;
        // such samples still go through but the flag stays up until standby.
        if (conv_fall && q.st != ST_STANDBY && q.gap < GAP_WIDTH'(CONV_PERIOD_MIN_CYCLES - 1)) begin
            d.rate_viol = 1'b1;
        end

        d.standby = (d.st == ST_STANDBY);
        d.oe      = {WIDTH{~i_output_enable_n & ~i_standby_request}};
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st:        ST_STANDBY,
                   data:      DATA_RESET,
                   oe:        {WIDTH{DRIVE_RESET}},
                   standby:   STANDBY_RESET,
                   rate_viol: VIOLATION_RESET,
                   gap:       '0};
        end else begin
            q <= d;
        end
    end

    assign o_sample_word_lines    = q.data;
    assign o_sample_word_lines_oe = q.oe;
    assign o_standby_active       = q.standby;
    assign o_rate_violation       = q.rate_viol;
endmodule

// >>> verification/adc_port_properties.sv
// Pin-level checks of the converter output port.
`timescale 1ns/1ps
module adc_port_properties #(
    parameter int unsigned WIDTH = 10
) (
    // Clock, reset and inputs
    input wire logic             i_sys_clk,
    input wire logic             i_arst_n,
    input wire logic             i_conv_clk,
    input wire logic [WIDTH-1:0] i_analog_level,
    input wire logic             i_standby_request,
    input wire logic             i_output_enable_n,
    // Outputs
    input wire logic [WIDTH-1:0] o_sample_word_lines,
    input wire logic [WIDTH-1:0] o_sample_word_lines_oe,
    input wire logic             o_standby_active,
    input wire logic             o_rate_violation
);
    logic [2:0] up_q;
    logic       live;
    // Checks other than chk_standby_holds_word wait out the reset synchroniser so its lag is not taken for a fault.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end
    assign live = (up_q == 3'h7);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    chk_oe_follows_pins:
    assert property (live |-> o_sample_word_lines_oe == {WIDTH{$past(!i_output_enable_n && !i_standby_request)}})
        else $error("drive enable does not follow its pins");
    chk_standby_floats:
    assert property (live && i_standby_request |=> o_sample_word_lines_oe == '0) else $error("driving in standby");
    chk_standby_entered:
    assert property (live && $rose(i_standby_request) |-> ##[1:2] o_standby_active) else $error("standby not entered");
    chk_standby_holds_word:
    assert property (o_standby_active [*3] |-> $stable(o_sample_word_lines)) else $error("word moved in standby");
    chk_word_after_fall:
    assert property (live && !$stable(o_sample_word_lines) |-> $past(i_conv_clk, 3) && !$past(i_conv_clk, 2))
        else $error("word changed without a falling edge");
    chk_fill_keeps_word:
    assert property (live && $fell(o_standby_active) |-> $stable(o_sample_word_lines) [*6])
        else $error("word changed while the pipeline refills");
    chk_fast_falls_flagged:
    assert property (live && !o_standby_active && !i_standby_request && $fell(i_conv_clk) ##2 $fell(i_conv_clk)
        |-> ##[1:4] o_rate_violation) else $error("fast conversion clock not flagged");
endmodule

bind adc_parallel_output_port adc_port_properties #(.WIDTH(WIDTH)) u_port_properties (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_conv_clk(i_conv_clk), .i_analog_level(i_analog_level),
    .i_standby_request(i_standby_request), .i_output_enable_n(i_output_enable_n),
    .o_sample_word_lines(o_sample_word_lines), .o_sample_word_lines_oe(o_sample_word_lines_oe),
    .o_standby_active(o_standby_active), .o_rate_violation(o_rate_violation)
);

// >>> verification/adc_capture_model.sv
// Capture logic model: makes the conversion clock and level, latches each word.
`timescale 1ns/1ps
module adc_capture_model
    import adc_pkg::*;
(
    // Bench control
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_run,
    input  wire logic [3:0]              i_half,
    input  wire logic [SAMPLE_WIDTH-1:0] i_start,
    input  wire logic [SAMPLE_WIDTH-1:0] i_step,
    // Converter pins
    output logic                         o_conv_clk = 1'b1,
    output logic [SAMPLE_WIDTH-1:0]      o_level = '0,
    input  wire logic [SAMPLE_WIDTH-1:0] i_word,
    input  wire logic [SAMPLE_WIDTH-1:0] i_word_oe,
    // Captured words
    output logic [SAMPLE_WIDTH-1:0]      o_captured = '0,
    output int                           o_n_captures = 0
);
    logic [3:0] phase_q = 4'h0;
    // The clock stands high between runs so no stray fall reaches the converter.
    always @(posedge i_sys_clk) begin
        if (!i_run) begin
            phase_q <= 4'h0;
            o_conv_clk <= 1'b1;
            o_level <= i_start;
        end else if (phase_q != i_half - 4'h1) begin
            phase_q <= phase_q + 4'h1;
        end else begin
            phase_q <= 4'h0;
            o_conv_clk <= ~o_conv_clk;
            if (o_conv_clk) begin
                o_level <= o_level + i_step;
            end else begin
                // A floating bus reads back inverted so it never passes for a held word.
                o_captured <= (i_word_oe == '1) ? i_word : ~o_captured;
                o_n_captures <= o_n_captures + 1;
            end
        end
    end
endmodule

// >>> verification/adc_parallel_output_port_tb_top.sv
// Bench of the converter output port against its capture partner.
`timescale 1ns/1ps
module adc_parallel_output_port_tb_top;
    import adc_pkg::*;
    typedef logic [SAMPLE_WIDTH-1:0] word_type;
    logic       clk = 1'b0, arst_n = 1'b0, stby = 1'b0, oe_n = 1'b0, run = 1'b0;
    logic       conv, act, viol;
    logic [3:0] half = 4'h4;
    word_type   level, word, oe, cap, start = '0, step = '0, last;
    int         n_caps, n_mismatch = 0, n_checks = 0;
    always #5 clk = ~clk;
    adc_parallel_output_port DUT (.i_sys_clk(clk), .i_arst_n(arst_n), .i_conv_clk(conv), .i_analog_level(level),
        .i_standby_request(stby), .i_output_enable_n(oe_n), .o_sample_word_lines(word),
        .o_sample_word_lines_oe(oe), .o_standby_active(act), .o_rate_violation(viol));
    adc_capture_model u_model (.i_sys_clk(clk), .i_run(run), .i_half(half), .i_start(start), .i_step(step),
        .o_conv_clk(conv), .o_level(level), .i_word(word), .i_word_oe(oe), .o_captured(cap), .o_n_captures(n_caps));

    task automatic check(input string name, input word_type seen, input word_type exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_caps(input int target);
        for (int i = 0; i < 100; i++) begin
            if (n_caps >= target) return;
            tick(1);
        end
        $display("Error capture %0d never came", target);
        n_mismatch++;
        end_of_test();
    endtask
    // Six falls: the first two only refill the pipeline and show the held word.
    task automatic run_stream(input word_type first, input word_type inc, input word_type stale);
        int base;
        base = n_caps;
        @(posedge clk);
        start <= first;
        step <= inc;
        @(posedge clk);
        run <= 1'b1;
        for (int k = 1; k <= 6; k++) begin
            wait_caps(base + k);
            if (k <= 2) check("refill word", cap, stale);
            else check("word", cap, word_type'(first + word_type'(k - 2) * inc));
        end
        last = word_type'(first + word_type'(4) * inc);
        @(posedge clk);
        run <= 1'b0;
    endtask
    task automatic oe_scenario;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk);
            stby <= c[1];
            oe_n <= c[0];
            tick(2);
            check("drive enable", oe, {SAMPLE_WIDTH{~c[0] & ~c[1]}});
        end
        @(posedge clk);
        stby <= 1'b0;
        oe_n <= 1'b0;
        tick(4);
    endtask
    task automatic standby_scenario;
        @(posedge clk);
        stby <= 1'b1;
        tick(3);
        check("standby flag", word_type'(act), word_type'(1'b1));
        check("drive in standby", oe, '0);
        @(posedge clk);
        start <= 10'h0AA;
        step <= 10'h155;
        @(posedge clk);
        run <= 1'b1;
        wait_caps(n_caps + 4);
        check("word in standby", word, last);
        @(posedge clk);
        run <= 1'b0;
        @(posedge clk);
        stby <= 1'b0;
        tick(6);
        run_stream(10'h2AA, 10'h155, last);
    endtask
    task automatic rate_scenario;
        @(posedge clk);
        half <= 4'h1;
        run <= 1'b1;
        wait_caps(n_caps + 4);
        check("rate flag", word_type'(viol), word_type'(1'b1));
        @(posedge clk);
        run <= 1'b0;
        half <= 4'h4;
        stby <= 1'b1;
        tick(4);
        check("rate flag in standby", word_type'(viol), '0);
        @(posedge clk);
        stby <= 1'b0;
        tick(4);
    endtask

    initial begin
        tick(3);
        check("reset word", word, DATA_RESET);
        check("reset drive", oe, {SAMPLE_WIDTH{DRIVE_RESET}});
        check("reset standby", word_type'(act), word_type'(STANDBY_RESET));
        check("reset rate flag", word_type'(viol), word_type'(VIOLATION_RESET));
        @(posedge clk);
        arst_n <= 1'b1;
        tick(6);
        run_stream(10'h3FD, 10'h001, DATA_RESET);
        oe_scenario();
        standby_scenario();
        rate_scenario();
        end_of_test();
    end
endmodule
